//--- nio_override.sv
// per-channel override of kernel digital inputs and outputs by the plc
// assumes plc and kernel ports on sys_clk; input pins are asynchronous
`timescale 1ns/1ps
module nio_override
    import nio_pkg::*;
#(
    parameter int NGRP = NIO_MAX_GRP
)(
    input wire logic sys_clk, // 20 mhz system clock
    input wire logic rst, // async reset, active high
    input wire logic plc_cycle, // cyclic update pulse
    input wire logic plc_wr, // interface byte write strobe
    input wire logic plc_rd, // interface byte read strobe
    input wire logic [7:0] plc_addr, // interface byte offset
    input wire logic [7:0] plc_wdata, // write data
    output logic [7:0] plc_rdata_r, // read data
    output logic plc_rvalid_r, // read data valid pulse
    input wire logic [8*NGRP-1:0] din_pin, // digital input pins
    output logic [8*NGRP-1:0] din_kern_r, // inputs seen by kernel
    input wire logic [8*NGRP-1:0] kern_we, // kernel output write enables
    input wire logic [8*NGRP-1:0] kern_wval, // kernel output values
    output logic [8*NGRP-1:0] kval_r, // stored kernel output values
    output logic [8*NGRP-1:0] dout_pin_r // digital output pins
);

    localparam int NCH = 8 * NGRP;

    // --------------------------------------------------------------
    // elaboration check
    // --------------------------------------------------------------
    if (NGRP < 1 || NGRP > NIO_MAX_GRP) begin : g_bad_ngrp
        $error("nio_override: NGRP out of range");
    end

    // --------------------------------------------------------------
    // declarations
    // --------------------------------------------------------------
    nio_ctl_t shadow_r;
    nio_ctl_t shadow_nxt;
    nio_ctl_t act_r;
    nio_ctl_t act_nxt;
    logic [NCH-1:0] sync1_r;
    logic [NCH-1:0] sync2_r;
    logic [NCH-1:0] sync3_r;
    logic [NCH-1:0] din_lvl_r;
    logic [NCH-1:0] din_lvl_nxt;
    logic [NCH-1:0] din_kern_nxt;
    logic [NCH-1:0] ow_prev_r;
    logic [NCH-1:0] ow_rise;
    logic [NCH-1:0] kval_nxt;
    logic [NCH-1:0] dout_pin_nxt;
    logic [7:0] plc_rdata_nxt;
    logic plc_rvalid_nxt;

    // --------------------------------------------------------------
    // plc interface bytes
    // --------------------------------------------------------------

    // byte writes land in the shadow copy
    always_comb begin
        shadow_nxt = shadow_r;
        if (plc_wr) begin
            for (int g = 0; g < NGRP; g++) begin
                if (plc_addr == NIO_OFF_DIN_DIS[g]) begin
                    shadow_nxt.din_dis[8*g +: 8] = plc_wdata;
                end else if (plc_addr == NIO_OFF_DIN_FRC[g]) begin
                    shadow_nxt.din_frc[8*g +: 8] = plc_wdata;
                end else if (plc_addr == NIO_OFF_DOUT_DIS[g]) begin
                    shadow_nxt.dout_dis[8*g +: 8] = plc_wdata;
                end else if (plc_addr == NIO_OFF_DOUT_OW[g]) begin
                    shadow_nxt.dout_ow[8*g +: 8] = plc_wdata;
                end else if (plc_addr == NIO_OFF_SET_VAL[g]) begin
                    shadow_nxt.set_val[8*g +: 8] = plc_wdata; // [RULE_12]
                end else if (plc_addr == NIO_OFF_SET_MSK[g]) begin
                    shadow_nxt.set_msk[8*g +: 8] = plc_wdata;
                end
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            shadow_r <= NIO_RST_CTL;
        end else begin
            shadow_r <= shadow_nxt;
        end
    end

    // byte reads, unmapped offsets give zero
    always_comb begin
        plc_rdata_nxt = NIO_RST_BYTE;
        plc_rvalid_nxt = plc_rd;
        if (plc_rd) begin
            for (int g = 0; g < NGRP; g++) begin
                if (plc_addr == NIO_OFF_DIN_DIS[g]) begin
                    plc_rdata_nxt = shadow_r.din_dis[8*g +: 8];
                end else if (plc_addr == NIO_OFF_DIN_FRC[g]) begin
                    plc_rdata_nxt = shadow_r.din_frc[8*g +: 8];
                end else if (plc_addr == NIO_OFF_DOUT_DIS[g]) begin
                    plc_rdata_nxt = shadow_r.dout_dis[8*g +: 8];
                end else if (plc_addr == NIO_OFF_DOUT_OW[g]) begin
                    plc_rdata_nxt = shadow_r.dout_ow[8*g +: 8];
                end else if (plc_addr == NIO_OFF_SET_VAL[g]) begin
                    plc_rdata_nxt = shadow_r.set_val[8*g +: 8];
                end else if (plc_addr == NIO_OFF_SET_MSK[g]) begin
                    plc_rdata_nxt = shadow_r.set_msk[8*g +: 8];
                end else if (plc_addr == NIO_OFF_IN_ACT[g]) begin
                    plc_rdata_nxt = din_kern_r[8*g +: 8]; // actual inputs
                end
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            plc_rdata_r <= NIO_RST_BYTE;
            plc_rvalid_r <= 1'b0;
        end else begin
            plc_rdata_r <= plc_rdata_nxt;
            plc_rvalid_r <= plc_rvalid_nxt;
        end
    end

    // --------------------------------------------------------------
    // cyclic update
    // --------------------------------------------------------------

    // all control bytes applied together once per update
    always_comb begin
        act_nxt = act_r;
        if (plc_cycle) begin
            act_nxt = shadow_r; // [RULE_15]
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            act_r <= NIO_RST_CTL;
        end else begin
            act_r <= act_nxt;
        end
    end

    // --------------------------------------------------------------
    // digital inputs
    // --------------------------------------------------------------

    // pin level accepted once stages two and three agree
    always_comb begin
        din_lvl_nxt = (sync2_r & sync3_r) | (din_lvl_r & (sync2_r | sync3_r));
    end

    // force over disable over pin level
    always_comb begin
        din_kern_nxt = act_r.din_frc[NCH-1:0] // [RULE_03]
            | (~act_r.din_dis[NCH-1:0] & din_lvl_r); // [RULE_01] [RULE_02] [RULE_04]
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sync1_r <= '0;
            sync2_r <= '0;
            sync3_r <= '0;
            din_lvl_r <= '0;
            din_kern_r <= '0;
        end else begin
            sync1_r <= din_pin;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            din_lvl_r <= din_lvl_nxt;
            din_kern_r <= din_kern_nxt;
        end
    end

    // --------------------------------------------------------------
    // digital outputs
    // --------------------------------------------------------------

    // rising edge of the applied overwrite bits
    assign ow_rise = act_r.dout_ow[NCH-1:0] & ~ow_prev_r; // [RULE_09]

    // kernel value: overwrite edge beats a kernel write
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            if (ow_rise[i]) begin
                kval_nxt[i] = act_r.set_val[i]; // [RULE_07] [RULE_08]
            end else if (kern_we[i]) begin
                kval_nxt[i] = kern_wval[i];
            end else begin
                kval_nxt[i] = kval_r[i];
            end
        end
    end

    // pin: disable, then setting mask, then kernel value
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            if (act_r.dout_dis[i]) begin
                dout_pin_nxt[i] = 1'b0; // [RULE_05] [RULE_16]
            end else if (act_r.set_msk[i]) begin
                dout_pin_nxt[i] = act_r.set_val[i]; // [RULE_13] [RULE_14]
            end else begin
                dout_pin_nxt[i] = kval_r[i]; // [RULE_06]
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ow_prev_r <= '0;
            kval_r <= '0;
            dout_pin_r <= '0;
        end else begin
            ow_prev_r <= act_r.dout_ow[NCH-1:0];
            kval_r <= kval_nxt;
            dout_pin_r <= dout_pin_nxt;
        end
    end

    // --------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    // disabled and unforced inputs read zero
    AST_DIN_DISABLE: // [RULE_01]
        assert property ((din_kern_r & $past(act_r.din_dis[NCH-1:0]
            & ~act_r.din_frc[NCH-1:0])) == '0)
        else $error("disabled input not zero");

    // free inputs follow the filtered pin level
    AST_DIN_PASS: // [RULE_02] [RULE_04]
        assert property (((din_kern_r ^ $past(din_lvl_r))
            & $past(~act_r.din_dis[NCH-1:0] & ~act_r.din_frc[NCH-1:0])) == '0)
        else $error("enabled input does not follow pin");

    // forced inputs read one
    AST_DIN_FORCE: // [RULE_03]
        assert property ((~din_kern_r & $past(act_r.din_frc[NCH-1:0])) == '0)
        else $error("forced input not one");

    // disabled outputs are low
    AST_DOUT_DISABLE: // [RULE_05]
        assert property ((dout_pin_r & $past(act_r.dout_dis[NCH-1:0])) == '0)
        else $error("disabled output not low");

    // masked outputs that are not disabled show the setting value
    AST_DOUT_MASK: // [RULE_13]
        assert property (((dout_pin_r ^ $past(act_r.set_val[NCH-1:0]))
            & $past(~act_r.dout_dis[NCH-1:0] & act_r.set_msk[NCH-1:0])) == '0)
        else $error("masked output not setting value");

    // unmasked outputs that are not disabled show the kernel value
    AST_DOUT_KERNEL: // [RULE_06]
        assert property (((dout_pin_r ^ $past(kval_r))
            & $past(~act_r.dout_dis[NCH-1:0] & ~act_r.set_msk[NCH-1:0])) == '0)
        else $error("output not kernel value");

    // overwrite edge loads the setting value
    AST_OW_LOAD: // [RULE_07]
        assert property ((ow_rise != '0) |=>
            (((kval_r ^ $past(act_r.set_val[NCH-1:0])) & $past(ow_rise)) == '0))
        else $error("overwrite did not load setting value");

    // without edge or kernel write the kernel value holds
    AST_OW_STEADY: // [RULE_09]
        assert property (((kval_r ^ $past(kval_r))
            & ~$past(ow_rise) & ~$past(kern_we)) == '0)
        else $error("kernel value changed without cause");

    // applied control only moves on an update pulse
    AST_CYCLE_HOLD: // [RULE_15]
        assert property (!plc_cycle |=> (act_r == $past(act_r)))
        else $error("control changed outside update");

    // --------------------------------------------------------------
    // plc port assertions
    // --------------------------------------------------------------

    // a read answers with one valid pulse a cycle later
    AST_RD_VALID: // [RULE_15]
        assert property (plc_rvalid_r == $past(plc_rd))
        else $error("read valid not one cycle after strobe");

    // without a read the data lines rest at zero
    AST_RD_IDLE: // [RULE_15]
        assert property (!plc_rd |=> (plc_rdata_r == NIO_RST_BYTE))
        else $error("read data not zero when idle");

    // a read of a control byte returns the shadow copy
    AST_RD_CTL: // [RULE_01]
        assert property ((plc_rd && plc_addr == NIO_OFF_DIN_DIS[0])
            |=> (plc_rdata_r == $past(shadow_r.din_dis[7:0])))
        else $error("control byte read wrong");

    // a read of the actual input byte returns the kernel view
    AST_RD_ACTUAL: // [RULE_02]
        assert property ((plc_rd && plc_addr == NIO_OFF_IN_ACT[0])
            |=> (plc_rdata_r == $past(din_kern_r[7:0])))
        else $error("actual input byte wrong");

    // a setting value write lands in the shadow copy
    AST_WR_LAND: // [RULE_12]
        assert property ((plc_wr && plc_addr == NIO_OFF_SET_VAL[0])
            |=> (shadow_r.set_val[7:0] == $past(plc_wdata)))
        else $error("setting value write lost");

    // shadow copy only moves on a write strobe
    AST_SHADOW_HOLD: // [RULE_15]
        assert property (!plc_wr |=> (shadow_r == $past(shadow_r)))
        else $error("shadow changed without write");

    // update pulse applies the whole shadow copy
    AST_CTL_LOAD: // [RULE_15]
        assert property (plc_cycle |=> (act_r == $past(shadow_r)))
        else $error("update did not apply shadow");

    // --------------------------------------------------------------
    // pin and kernel assertions
    // --------------------------------------------------------------

    // filtered level takes stage two where stages two and three agree
    AST_DIN_SETTLE: // [RULE_02]
        assert property (((din_lvl_r ^ $past(sync2_r)) & ~$past(sync2_r ^ sync3_r)) == '0)
        else $error("filtered level missed agreeing stages");

    // filtered level holds while stages two and three differ
    AST_DIN_HOLD: // [RULE_02]
        assert property (((din_lvl_r ^ $past(din_lvl_r)) & $past(sync2_r ^ sync3_r)) == '0)
        else $error("filtered level moved on a glitch");

    // a kernel write without overwrite edge stores the written value
    AST_KERN_WRITE: // [RULE_06]
        assert property (((kval_r ^ $past(kern_wval)) & $past(kern_we & ~ow_rise)) == '0)
        else $error("kernel write not stored");

    // masked setting value one drives level one on outputs that are not disabled
    AST_DOUT_LEVEL: // [RULE_14]
        assert property ((~dout_pin_r & $past(act_r.set_val[NCH-1:0]
            & act_r.set_msk[NCH-1:0] & ~act_r.dout_dis[NCH-1:0])) == '0)
        else $error("setting value one not driven high");

endmodule

//--- nio_pkg.sv
// constants, types and offsets for the digital i/o override block
// assumes one byte-wide plc write/read port and a cyclic update pulse
//
// Behaviour
// RULE_01: input disable bit 1 presents the input as defined 0.
// RULE_02: input disable bit 0 lets the kernel read the pin level.
// RULE_03: input force bit 1 presents 1, ignoring pin and disable.
// RULE_04: force bit 0 passes the pin only when disable is also 0.
// RULE_05: output disable bit 1 drives a defined 0 at the pin.
// RULE_06: output disable bit 0 drives kernel value or plc value.
// RULE_07: overwrite rising edge loads setting value into the kernel value.
// RULE_08: overwritten kernel value is lost; setting value becomes kernel value.
// RULE_09: overwrite acts only on 0-to-1; steady 1 or fall does nothing.
// RULE_10: plc clears the overwrite bit again in its next cycle; the plc model skips the clear when hold is set.
// RULE_11: plc never raises overwrite and setting mask together.
// RULE_12: one setting value byte serves both overwrite and setting mask.
// RULE_13: mask 0 drives kernel value; mask 1 drives setting value, keeps kernel.
// RULE_14: setting value 1 gives level 1, value 0 gives level 0.
// RULE_15: control bytes sampled once per cyclic update, bit per channel.
// RULE_16: output priority: disable, then setting mask, then kernel value.
package nio_pkg;

    // --------------------------------------------------------------
    // geometry
    // --------------------------------------------------------------
    localparam int NIO_MAX_GRP = 5;
    localparam int NIO_MAX_CH = 8 * NIO_MAX_GRP;

    typedef logic [7:0] nio_off_t;
    typedef logic [NIO_MAX_CH-1:0] nio_vec_t;

    // --------------------------------------------------------------
    // byte offsets, one entry per group of eight channels
    // --------------------------------------------------------------
    localparam nio_off_t [0:NIO_MAX_GRP-1] NIO_OFF_DIN_DIS = '{
        8'h00, 8'h7a, 8'h7c, 8'h7e, 8'h80};
    localparam nio_off_t [0:NIO_MAX_GRP-1] NIO_OFF_DIN_FRC = '{
        8'h01, 8'h7b, 8'h7d, 8'h7f, 8'h81};
    localparam nio_off_t [0:NIO_MAX_GRP-1] NIO_OFF_DOUT_DIS = '{
        8'h04, 8'h82, 8'h86, 8'h8a, 8'h8e};
    localparam nio_off_t [0:NIO_MAX_GRP-1] NIO_OFF_DOUT_OW = '{
        8'h05, 8'h83, 8'h87, 8'h8b, 8'h8f};
    localparam nio_off_t [0:NIO_MAX_GRP-1] NIO_OFF_SET_VAL = '{
        8'h06, 8'h84, 8'h88, 8'h8c, 8'h90};
    localparam nio_off_t [0:NIO_MAX_GRP-1] NIO_OFF_SET_MSK = '{
        8'h07, 8'h85, 8'h89, 8'h8d, 8'h91};
    localparam nio_off_t [0:NIO_MAX_GRP-1] NIO_OFF_IN_ACT = '{
        8'h3c, 8'h3d, 8'h3e, 8'h3f, 8'h40};

    // --------------------------------------------------------------
    // reset values
    // --------------------------------------------------------------
    localparam nio_vec_t NIO_RST_VEC = 40'h00_0000_0000;
    localparam logic [7:0] NIO_RST_BYTE = 8'h00;

    // control bytes of all groups, one bit per channel
    typedef struct packed {
        nio_vec_t din_dis;
        nio_vec_t din_frc;
        nio_vec_t dout_dis;
        nio_vec_t dout_ow;
        nio_vec_t set_val;
        nio_vec_t set_msk;
    } nio_ctl_t;

    localparam nio_ctl_t NIO_RST_CTL = '{
        NIO_RST_VEC, NIO_RST_VEC, NIO_RST_VEC,
        NIO_RST_VEC, NIO_RST_VEC, NIO_RST_VEC};

endpackage

//--- nio_plc_model.sv
// plc user program model: byte writes, byte reads and cyclic update pulses
// assumes the override block samples its plc port on the rising sys_clk edge
`timescale 1ns/1ps
module nio_plc_model
    import nio_pkg::*;
(
    input wire logic sys_clk, // system clock
    output logic plc_cycle, // cyclic update pulse
    output logic plc_wr, // write strobe
    output logic plc_rd, // read strobe
    output logic [7:0] plc_addr, // byte offset
    output logic [7:0] plc_wdata, // write data
    input wire logic [7:0] plc_rdata_r, // read data
    input wire logic plc_rvalid_r // read valid pulse
);
    nio_vec_t msk_sh = '0; // setting mask bytes written so far

    // idle bus at time zero
    initial begin
        plc_cycle = 1'b0;
        plc_wr = 1'b0;
        plc_rd = 1'b0;
        plc_addr = 8'h00;
        plc_wdata = 8'h00;
    end

    // one byte write; released bus shows inverted junk, not the old value
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        for (int g = 0; g < NIO_MAX_GRP; g++) begin
            if (a == NIO_OFF_SET_MSK[g]) msk_sh[8*g+:8] = d;
        end
        @(posedge sys_clk);
        plc_wr <= 1'b1;
        plc_addr <= a;
        plc_wdata <= d;
        @(posedge sys_clk);
        plc_wr <= 1'b0;
        plc_addr <= ~a;
        plc_wdata <= ~d;
    endtask

    // one byte read; answer stands for the one cycle after the strobe edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge sys_clk);
        plc_rd <= 1'b1;
        plc_addr <= a;
        @(posedge sys_clk);
        plc_rd <= 1'b0;
        plc_addr <= ~a;
        #1;
        d = plc_rdata_r;
        v = plc_rvalid_r;
    endtask

    // one cyclic update pulse
    task automatic pulse();
        @(posedge sys_clk);
        plc_cycle <= 1'b1;
        @(posedge sys_clk);
        plc_cycle <= 1'b0;
    endtask

    // raise overwrite bits, skipping masked channels, then clear next cycle unless hold is set
    task automatic overwrite(input nio_vec_t ow, input logic hold);
        for (int g = 0; g < NIO_MAX_GRP; g++) begin
            wr(NIO_OFF_DOUT_OW[g], ow[8*g+:8] & ~msk_sh[8*g+:8]);
        end
        pulse();
        if (!hold) begin
            for (int g = 0; g < NIO_MAX_GRP; g++) wr(NIO_OFF_DOUT_OW[g], 8'h00);
            pulse();
        end
    endtask
endmodule

//--- tb.sv
// self-checking bench for the digital i/o override block
// assumes the plc model in nio_plc_model.sv drives the plc port
`timescale 1ns/1ps
module tb
    import nio_pkg::*;
();
    logic sys_clk, rst, plc_cycle, plc_wr, plc_rd, plc_rvalid_r;
    logic [7:0] plc_addr, plc_wdata, plc_rdata_r, rb;
    logic rv;
    nio_vec_t din_pin, din_kern_r, kern_we, kern_wval, kval_r, dout_pin_r;
    nio_vec_t kv, dis, msk, sv;
    int mismatches = 0;
    int num_checks = 0;

    // ----------------------------------------------------------------
    // design and plc model
    // ----------------------------------------------------------------
    nio_override #(.NGRP(NIO_MAX_GRP)) DUT (.sys_clk(sys_clk), .rst(rst),
        .plc_cycle(plc_cycle), .plc_wr(plc_wr), .plc_rd(plc_rd), .plc_addr(plc_addr),
        .plc_wdata(plc_wdata), .plc_rdata_r(plc_rdata_r), .plc_rvalid_r(plc_rvalid_r),
        .din_pin(din_pin), .din_kern_r(din_kern_r), .kern_we(kern_we),
        .kern_wval(kern_wval), .kval_r(kval_r), .dout_pin_r(dout_pin_r));
    nio_plc_model plc (.sys_clk(sys_clk), .plc_cycle(plc_cycle), .plc_wr(plc_wr),
        .plc_rd(plc_rd), .plc_addr(plc_addr), .plc_wdata(plc_wdata),
        .plc_rdata_r(plc_rdata_r), .plc_rvalid_r(plc_rvalid_r));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic chk40(input nio_vec_t exp, input nio_vec_t got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic chk8(input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    // offset of control kind k in group g
    function automatic nio_off_t off_of(input int k, input int g);
        case (k)
            0: return NIO_OFF_DIN_DIS[g];
            1: return NIO_OFF_DIN_FRC[g];
            2: return NIO_OFF_DOUT_DIS[g];
            3: return NIO_OFF_DOUT_OW[g];
            4: return NIO_OFF_SET_VAL[g];
            default: return NIO_OFF_SET_MSK[g];
        endcase
    endfunction

    task automatic put(input int k, input nio_vec_t v);
        for (int g = 0; g < NIO_MAX_GRP; g++) plc.wr(off_of(k, g), v[8*g+:8]);
    endtask

    task automatic settle();
        repeat (6) @(posedge sys_clk);
        #1;
    endtask

    task automatic kwrite(input nio_vec_t v);
        @(posedge sys_clk);
        kern_we <= '1;
        kern_wval <= v;
        @(posedge sys_clk);
        kern_we <= '0;
        kern_wval <= ~v;
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // clock, reset, watchdog
    // ----------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        report_and_stop();
    end

    // ----------------------------------------------------------------
    // test sequence
    // ----------------------------------------------------------------
    initial begin
        rst = 1'b1;
        din_pin = '0;
        kern_we = '0;
        kern_wval = '0;
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        settle();
        chk40('0, dout_pin_r);
        chk40('0, kval_r);
        chk40('0, din_kern_r);
        $display("test reset done");
        // control bytes read back; no pulse means no effect at the pins
        for (int k = 0; k < 6; k++)
            for (int g = 0; g < NIO_MAX_GRP; g++) plc.wr(off_of(k, g), 8'(16*g+k) ^ 8'h5a);
        plc.wr(8'h02, 8'hff);
        settle();
        chk40('0, dout_pin_r);
        for (int k = 0; k < 6; k++)
            for (int g = 0; g < NIO_MAX_GRP; g++) begin
                plc.rd(off_of(k, g), rb, rv);
                chk8(8'(16*g+k) ^ 8'h5a, rb);
                chk8(8'h01, {7'h00, rv});
            end
        plc.rd(8'h02, rb, rv);
        chk8(8'h00, rb);
        for (int k = 0; k < 6; k++) put(k, '0);
        plc.pulse();
        $display("test registers done");
        // input disable and force
        din_pin <= 40'hc3_a5_5a_96_69;
        dis = 40'hf0_00_00_00_0f;
        sv = 40'h01_00_00_ff_33;
        put(0, dis);
        put(1, sv);
        plc.pulse();
        settle();
        chk40(sv | (40'hc3_a5_5a_96_69 & ~dis), din_kern_r);
        for (int g = 0; g < NIO_MAX_GRP; g++) begin
            plc.rd(NIO_OFF_IN_ACT[g], rb, rv);
            chk8(sv[8*g+:8] | (din_pin[8*g+:8] & ~dis[8*g+:8]), rb);
        end
        $display("test inputs done");
        // kernel writes, then disable and setting mask on outputs
        kv = 40'h12_34_56_78_9a;
        kwrite(kv);
        settle();
        chk40(kv, kval_r);
        chk40(kv, dout_pin_r);
        dis = 40'h00_00_00_00_0f;
        msk = 40'h80_00_00_ff_f0;
        sv = 40'hff_00_ff_0f_cc;
        put(2, dis);
        put(4, sv);
        put(5, msk);
        plc.pulse();
        settle();
        chk40(~dis & ((msk & sv) | (~msk & kv)), dout_pin_r);
        chk40(kv, kval_r);
        $display("test outputs done");
        // overwrite of unmasked channels from the shared setting value
        plc.overwrite('1, 1'b0);
        settle();
        kv = (kv & msk) | (sv & ~msk);
        chk40(kv, kval_r);
        chk40(~dis & ((msk & sv) | (~msk & kv)), dout_pin_r);
        // overwrite held high, then steady and falling levels act on nothing
        put(5, '0);
        plc.pulse();
        plc.overwrite(40'h00_00_00_00_f0, 1'b1);
        settle();
        kv = (kv & ~40'h00_00_00_00_f0) | (sv & 40'h00_00_00_00_f0);
        chk40(kv, kval_r);
        kv = 40'h0f_0f_0f_0f_0f;
        kwrite(kv);
        plc.pulse();
        settle();
        chk40(kv, kval_r);
        plc.overwrite('0, 1'b0);
        settle();
        chk40(kv, kval_r);
        chk40(kv & ~dis, dout_pin_r);
        $display("test overwrite done");
        // reset in mid-run clears control bytes, kernel value and outputs
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        settle();
        chk40('0, kval_r);
        chk40('0, dout_pin_r);
        chk40(40'hc3_a5_5a_96_69, din_kern_r);
        plc.rd(NIO_OFF_DOUT_DIS[0], rb, rv);
        chk8(8'h00, rb);
        chk8(8'h01, {7'h00, rv});
        $display("test mid-run reset done");
        report_and_stop();
    end
endmodule
